// *** rtrb_params.svh ***
// Behaviour
// R1: serial-out select 0: serial data pin carries only serial interface output.
// R2: serial-out select 1: serial output while chip select low, data clock while high.
// R3: serial-in select 0: serial data input pin is only serial interface input.
// R4: serial-in select 1: serial input while select low, bidirectional data line while high.
// R5: amplifier enable 0 holds control output low; 1 follows chosen window.
// R6: timing select 0 gives transmit-on window, 1 gives amplifier-on window.
// R7: normal frequency word is high byte 15:8 and low byte 7:0.
// R8: host programs half the desired intermediate frequency value.
// R9: assessment frequency word replaces normal word during channel assessment.
// R10: ten-bit capacitance trim from two low bits and a full byte.
// R11: band coefficient is binary weighted, bit7 one down to bit0 1/128.
// R12: separate assessment band coefficient applies during channel assessment.
// R13: both frequency words reset to high 0x38, low 0xb6.
// R14: capacitance resets high bits 10, low 0x4a; coefficients reset 0x80.
// R15: pin select and amplifier control register resets to zero.
// R16: host writes reserved bits and registers as zero, ignores their reads.
`ifndef RTRB_PARAMS_SVH
`define RTRB_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTRB_OFS_PIN_AMP 7'h53
`define RTRB_OFS_IF_H 7'h54
`define RTRB_OFS_IF_L 7'h55
`define RTRB_OFS_IFA_H 7'h56
`define RTRB_OFS_IFA_L 7'h57
`define RTRB_OFS_CAP_H 7'h58
`define RTRB_OFS_CAP_L 7'h59
`define RTRB_OFS_RSV_A 7'h5a
`define RTRB_OFS_RSV_B 7'h5b
`define RTRB_OFS_COEF 7'h5c
`define RTRB_OFS_COEFA 7'h5d
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RTRB_BIT_SO_SEL 5
`define RTRB_BIT_SI_SEL 4
`define RTRB_BIT_AMP_TIM 1
`define RTRB_BIT_AMP_EN 0
`define RTRB_RST_PIN_AMP 8'h00
`define RTRB_RST_IF_H 8'h38
`define RTRB_RST_IF_L 8'hb6
`define RTRB_RST_CAP_H 2'h2
`define RTRB_RST_CAP_L 8'h4a
`define RTRB_RST_COEF 8'h80
`endif

// *** rtrb_pkg.sv ***
package rtrb_pkg;
  // tuning values handed to the radio
  typedef struct packed {
    logic [15:0] inter_freq_word;
    logic [9:0] filter_cap_trim;
    logic [7:0] filter_band_coeff;
  } rtrb_tune_s;
endpackage : rtrb_pkg

// *** rtrb_bank.sv ***
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "rtrb_params.svh"
module rtrb_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // radio state
  input wire logic assess_active_i,
  input wire logic tx_on_window_i,
  input wire logic amp_on_window_i,
  input wire logic direct_data_clock_i,
  input wire logic direct_data_out_i,
  input wire logic direct_data_oe_i,
  input wire logic serial_data_out_i,
  // serial pins
  input wire logic chip_select_n_i,
  input wire logic sdin_pin_i,
  output logic sdin_pin_o,
  output logic sdin_pin_oe_o,
  output logic sdout_pin_o,
  output logic serial_data_in_o,
  output logic direct_data_in_o,
  output logic amp_ctrl_o,
  // tuning outputs
  output rtrb_pkg::rtrb_tune_s tune_o
);
  import rtrb_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] pin_amp_r, if_h_r, if_l_r, ifa_h_r, ifa_l_r, cap_l_r, coef_r, coefa_r;
  logic [1:0] cap_h_r;
  logic ack_r, err_r;
  logic [31:0] dat_r;

  // bus decode
  wire [6:0] idx = wb_adr_i[8:2];
  wire req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  wire mapped = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[31:9] == 23'h0) &&
                (idx >= `RTRB_OFS_PIN_AMP) && (idx <= `RTRB_OFS_COEFA);
  wire wr = req && mapped && wb_we_i && wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];

  // read mux; reserved bits and registers read zero
  logic [7:0] rd;
  always_comb begin
    unique case (idx)
      `RTRB_OFS_PIN_AMP: rd = pin_amp_r & 8'h33;
      `RTRB_OFS_IF_H: rd = if_h_r;
      `RTRB_OFS_IF_L: rd = if_l_r;
      `RTRB_OFS_IFA_H: rd = ifa_h_r;
      `RTRB_OFS_IFA_L: rd = ifa_l_r;
      `RTRB_OFS_CAP_H: rd = {6'h0, cap_h_r};
      `RTRB_OFS_CAP_L: rd = cap_l_r;
      `RTRB_OFS_COEF: rd = coef_r;
      `RTRB_OFS_COEFA: rd = coefa_r;
      default: rd = 8'h00;
    endcase
  end

  // register writes and bus answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // R15 control reset
      pin_amp_r <= `RTRB_RST_PIN_AMP;
      // R13 frequency reset
      if_h_r <= `RTRB_RST_IF_H;
      if_l_r <= `RTRB_RST_IF_L;
      ifa_h_r <= `RTRB_RST_IF_H;
      ifa_l_r <= `RTRB_RST_IF_L;
      // R14 filter reset
      cap_h_r <= `RTRB_RST_CAP_H;
      cap_l_r <= `RTRB_RST_CAP_L;
      coef_r <= `RTRB_RST_COEF;
      coefa_r <= `RTRB_RST_COEF;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req && mapped;
      err_r <= req && !mapped;
      if (req) begin
        dat_r <= {24'h0, mapped ? rd : 8'h00};
      end
      if (wr) begin
        unique case (idx)
          `RTRB_OFS_PIN_AMP: pin_amp_r <= wd & 8'h33;
          `RTRB_OFS_IF_H: if_h_r <= wd;
          `RTRB_OFS_IF_L: if_l_r <= wd;
          `RTRB_OFS_IFA_H: ifa_h_r <= wd;
          `RTRB_OFS_IFA_L: ifa_l_r <= wd;
          `RTRB_OFS_CAP_H: cap_h_r <= wd[1:0];
          `RTRB_OFS_CAP_L: cap_l_r <= wd;
          `RTRB_OFS_COEF: coef_r <= wd;
          `RTRB_OFS_COEFA: coefa_r <= wd;
          default: ;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // pin steering
  // ----------------------------------------
  wire so_sel = pin_amp_r[`RTRB_BIT_SO_SEL];
  wire si_sel = pin_amp_r[`RTRB_BIT_SI_SEL];
  wire cs_high = chip_select_n_i;
  wire direct_mode = si_sel && cs_high;

  // R1 serial only
  // R2 clock when deselected
  assign sdout_pin_o = (so_sel && cs_high) ? direct_data_clock_i : serial_data_out_i;
  // R3 serial input only
  // R4 direct data line
  assign serial_data_in_o = direct_mode ? 1'b0 : sdin_pin_i;
  assign direct_data_in_o = direct_mode ? sdin_pin_i : 1'b0;
  assign sdin_pin_o = direct_mode ? direct_data_out_i : 1'b0;
  assign sdin_pin_oe_o = direct_mode && direct_data_oe_i;

  // R5 enable gate
  // R6 window select
  assign amp_ctrl_o = pin_amp_r[`RTRB_BIT_AMP_EN] &&
                      (pin_amp_r[`RTRB_BIT_AMP_TIM] ? amp_on_window_i : tx_on_window_i);

  // ----------------------------------------
  // tuning values
  // ----------------------------------------
  // R7 normal word
  // R9 assessment word
  assign tune_o.inter_freq_word = assess_active_i ? {ifa_h_r, ifa_l_r} : {if_h_r, if_l_r};
  // R10 capacitance trim
  assign tune_o.filter_cap_trim = {cap_h_r, cap_l_r};
  // R11 weighted coefficient
  // R12 assessment coefficient
  assign tune_o.filter_band_coeff = assess_active_i ? coefa_r : coef_r;
endmodule : rtrb_bank
`default_nettype wire

// *** rtrb_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtrb_host (
  input wire logic oe_i,
  input wire logic d_i,
  input wire logic hd_i,
  output logic pin_o
);
  assign pin_o = oe_i ? d_i : hd_i;
endmodule : rtrb_host
`default_nettype wire

// *** rtrb_bank_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtrb_bank_chk (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, chip_select_n_i, serial_data_out_i,
  input wire logic sdout_pin_o, sdin_pin_oe_o, direct_data_oe_i, direct_data_in_o, amp_ctrl_o,
  input wire logic tx_on_window_i, amp_on_window_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff rst_i;
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
  sequence reply_s; (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
  bus_reply_a: assert property (take_s |=> reply_s) else $error("bad reply");
  reply_cause_a: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_stb_i)) else $error("stray reply");
  ack_err_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
  sdo_select_a:
    assert property (!chip_select_n_i |-> sdout_pin_o == serial_data_out_i) else $error("sdout wrong");
  dio_drive_a:
    assert property (sdin_pin_oe_o |-> chip_select_n_i && direct_data_oe_i) else $error("pin driven");
  dio_in_a:
    assert property (!chip_select_n_i |-> !direct_data_in_o) else $error("direct in wrong");
  amp_window_a:
    assert property (amp_ctrl_o |-> tx_on_window_i || amp_on_window_i) else $error("amp wrong");
  amp_reset_a:
    assert property ($fell(rst_i) |-> !amp_ctrl_o && !sdin_pin_oe_o) else $error("reset pins");
endmodule : rtrb_bank_chk
bind rtrb_bank rtrb_bank_chk chk_u(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .chip_select_n_i,
  .serial_data_out_i, .sdout_pin_o, .sdin_pin_oe_o, .direct_data_oe_i, .direct_data_in_o, .amp_ctrl_o,
  .tx_on_window_i, .amp_on_window_i);
`default_nettype wire

// *** tb_rtrb_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_rtrb_bank;
  import rtrb_pkg::*;
  logic clk_i=0, rst_i=1, wb_cyc_i=0, wb_stb_i=0, wb_we_i=0, assess_active_i=0, tx_on_window_i=0;
  logic amp_on_window_i=0, direct_data_clock_i=0, direct_data_out_i=0, direct_data_oe_i=0;
  logic serial_data_out_i=0, chip_select_n_i=1, hd=0, be;
  logic [31:0] wb_adr_i=0, wb_dat_i=0, wb_dat_o, rd;
  logic [3:0] wb_sel_i=0;
  logic wb_ack_o, wb_err_o, sdin_pin_i, sdin_pin_o, sdin_pin_oe_o, sdout_pin_o, serial_data_in_o;
  logic direct_data_in_o, amp_ctrl_o;
  rtrb_tune_s tune_o;
  int fail_count=0, n_compared=0, seed=32'hfd48, tick=0, i;
  logic [7:0] d;
  logic [7:0] m[11]='{8'h00, 8'h38, 8'hb6, 8'h38, 8'hb6, 8'h02, 8'h4a, 8'h00, 8'h00, 8'h80, 8'h80};
  rtrb_bank dut_u(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .assess_active_i, .tx_on_window_i, .amp_on_window_i, .direct_data_clock_i,
    .direct_data_out_i, .direct_data_oe_i, .serial_data_out_i, .chip_select_n_i, .sdin_pin_i, .sdin_pin_o,
    .sdin_pin_oe_o, .sdout_pin_o, .serial_data_in_o, .direct_data_in_o, .amp_ctrl_o, .tune_o);
  rtrb_host host_u(.oe_i(sdin_pin_oe_o), .d_i(sdin_pin_o), .hd_i(hd), .pin_o(sdin_pin_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++tick > 5000) begin fail_count++; summarize(); end
  function automatic logic [31:0] ra(int k); return 32'((32'h53 + k) * 4); endfunction : ra
  function automatic logic [7:0] mk(int k); return k==0 ? 8'h33 : k==5 ? 8'h03 : k==7||k==8 ? 8'h00 : 8'hff; endfunction : mk
  function automatic logic [33:0] et(logic a);
    return a ? {m[3], m[4], m[5][1:0], m[6], m[10]} : {m[1], m[2], m[5][1:0], m[6], m[9]};
  endfunction : et
  function automatic logic [33:0] ep();
    logic dm;
    dm = m[0][4] & chip_select_n_i;
    return {m[0][0] & (m[0][1] ? amp_on_window_i : tx_on_window_i), dm & direct_data_oe_i,
      m[0][5] & chip_select_n_i ? direct_data_clock_i : serial_data_out_i, dm ? 1'b0 : sdin_pin_i, dm & sdin_pin_i};
  endfunction : ep
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin fail_count++; $display("mismatch %0t got %h exp %h", $time, g, e); end
  endtask : cmp
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] v, input logic s);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 3'h0, s};
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    be = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : bus
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (i = 0; i < 11; i++) begin
      bus(0, ra(i), 8'h00, 1);
      cmp(rd, m[i]);
    end
    for (int j = 0; j < 80; j++) begin
      i = j < 16 ? 0 : $unsigned($random(seed)) % 11;
      d = $random(seed);
      if (j < 16) {d[5:4], d[1:0]} = j[3:0];
      // reserved bits and registers written as zero
      d = d & mk(i);
      // frequency bytes carry half the wanted value
      bus(1, ra(i), d, 1);
      m[i] = d & mk(i);
      bus(0, ra(i), 8'h00, 1);
      cmp(rd, m[i]);
      {assess_active_i, tx_on_window_i, amp_on_window_i, direct_data_clock_i, direct_data_out_i, direct_data_oe_i,
        serial_data_out_i, chip_select_n_i, hd} <= 9'($random(seed));
      @(negedge clk_i);
      cmp(tune_o, et(assess_active_i));
      cmp({amp_ctrl_o, sdin_pin_oe_o, sdout_pin_o, serial_data_in_o, direct_data_in_o}, ep());
      @(posedge clk_i);
    end
    bus(1, 32'h178, 8'hff, 1);
    cmp(be, 1'b1);
    bus(1, ra(1), ~m[1], 0);
    bus(0, ra(1), 8'h00, 1);
    cmp(rd, m[1]);
    summarize();
  end
endmodule : tb_rtrb_bank
`default_nettype wire
